// ---- rnr_checker.sv ----
// Purpose: port-level checks of the serial ROM readout block
// Assumes: one clk_sys domain, nrst synchronous active low
// Notes: bound into rnr_top below
`timescale 1ns/1ps
`include "rnr_defines.svh"
module rnr_checker (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // sync reset, active low
	input wire logic power_down, // power-down pin
	input wire logic address_strobe, // slice strobe pin
	input wire logic data_request_pulse, // request pin
	input wire logic nibble_select, // nibble choice pin
	input wire logic [7:0] parallel_data_out, // port drive value
	input wire logic parallel_data_oe, // port drive enable
	input wire logic serial_data_out, // serial bit
	input wire rnr_pkg::rnr_addr_type ext_addr_out, // address outputs
	input wire logic data_valid // data presented
);
	import rnr_pkg::*;
	logic [11:0] since_q;
	logic [11:0] since_d;
	logic req_q;
	logic stb_q;
	logic fall_seen;
	rnr_word_type rom_byte;
	// a request or strobe fall restarts the count, so the last one is the readout start
	assign fall_seen = (req_q && !data_request_pulse) || (stb_q && !address_strobe);
	assign since_d = fall_seen ? 12'H000 : ((since_q == 12'HFFF) ? since_q : since_q + 12'H001);
	assign rom_byte = ext_addr_out[7:0] ^ {ext_addr_out[13:8], 2'H0} ^ 8'H5A;
	always_ff @(posedge clk_sys) begin
		since_q <= nrst ? since_d : 12'HFFF;
		req_q <= data_request_pulse;
		stb_q <= address_strobe;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_access_time: assert property ($rose(data_valid) |-> since_q >= 12'H9FE && since_q <= 12'HA28)
		else $error("data valid outside access window");
	a_oe_match: assert property (nrst && $past(nrst) && $past(nrst, 2) && $stable(ext_addr_out)
		&& ext_addr_out == $past(ext_addr_out, 2) |-> parallel_data_oe == (ext_addr_out[17:14] == `RNR_CS_CODE))
		else $error("port enable disagrees with chip select");
	a_rom_byte: assert property ($rose(data_valid) && parallel_data_oe |-> ##2 parallel_data_out[7:4] == rom_byte[7:4])
		else $error("wrong stored byte presented");
	a_serial_first: assert property ($rose(data_valid) && parallel_data_oe && !nibble_select
		|-> ##2 serial_data_out == rom_byte[0] && parallel_data_out[0] == rom_byte[0])
		else $error("bit 0 not presented");
	a_pd_clear: assert property (power_down [*6] |-> ext_addr_out == 18'H00000 && !data_valid)
		else $error("power-down did not clear");
	a_pd_hold: assert property (power_down [*5] |-> $stable(serial_data_out) && $stable(parallel_data_out))
		else $error("data moved in power-down");
	a_serial_hold: assert property ((!data_request_pulse) [*5] ##0 (data_valid && $past(data_valid))
		|-> $stable(serial_data_out))
		else $error("serial bit moved without request");
	a_valid_hold: assert property ((!data_request_pulse && !address_strobe && !power_down) [*5] ##0 data_valid
		|=> data_valid)
		else $error("data valid dropped without cause");
endmodule : rnr_checker
bind rnr_top rnr_checker chk_u (.clk_sys(clk_sys), .nrst(nrst), .power_down(power_down),
	.address_strobe(address_strobe), .data_request_pulse(data_request_pulse), .nibble_select(nibble_select),
	.parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
	.serial_data_out(serial_data_out), .ext_addr_out(ext_addr_out), .data_valid(data_valid));

// ---- rnr_defines.svh ----
// Purpose: constants of the nibble-addressed serial ROM readout block
// Assumes: clk_sys at 100 MHz
// Notes: times are in ns; cycle counts derive from them
`ifndef RNR_DEFINES_SVH
`define RNR_DEFINES_SVH

`define RNR_ADDR_W 18
`define RNR_ROM_AW 14
`define RNR_WORD_W 8
`define RNR_FIFO_DEPTH 4
`define RNR_PIN_W 18

// address slice positions, first slice carries two bits only
`define RNR_SLICE_TOP 3'H0
`define RNR_SLICE_B 3'H1
`define RNR_SLICE_C 3'H2
`define RNR_SLICE_D 3'H3
`define RNR_SLICE_LAST 3'H4

// chip-select field and fixed code
`define RNR_CS_MSB 17
`define RNR_CS_LSB 14
`define RNR_CS_CODE 4'H0

// request pulses per serial word, last index
`define RNR_BIT_LAST 3'H7

`define RNR_CLK_NS 10
`define RNR_ACCESS_DELAY_NS 25600
`define RNR_ACCESS_CYC ((`RNR_ACCESS_DELAY_NS + `RNR_CLK_NS - 1) / `RNR_CLK_NS)
`define RNR_TIMER_W 12
// edges from an address move until the external byte is through the synchronisers
`define RNR_SETTLE_CYC 3

`endif

// ---- rnr_far_side.sv ----
// Purpose: base clock source and external memory beside the readout block
// Assumes: memory drives the port whenever the block does not
// Notes: memory byte is a fixed pattern of the low address
`timescale 1ns/1ps
module rnr_far_side (
	input wire rnr_pkg::rnr_addr_type ext_addr_out, // address from block
	input wire logic [7:0] parallel_data_out, // block drive value
	input wire logic parallel_data_oe, // block drive enable
	output logic base_clock_in, // base clock to block
	output logic [7:0] parallel_data_in // resolved port level
);
	import rnr_pkg::*;
	logic [7:0] mem_byte;
	assign mem_byte = ext_addr_out[7:0] ^ 8'HC3;
	assign parallel_data_in = parallel_data_oe ? parallel_data_out : mem_byte;
	// free running, phase unrelated to clk_sys
	initial begin
		base_clock_in = 1'H0;
		#7;
		forever #80 base_clock_in = ~base_clock_in;
	end
endmodule : rnr_far_side

// ---- rnr_fifo.sv ----
// Purpose: small word FIFO between fetch and presentation
// Assumes: DEPTH is a power of two
// Notes: flush empties it in one cycle
`timescale 1ns/1ps
module rnr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // sync reset, active low
	input wire logic flush, // drop all words
	input wire logic in_valid, // write request
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // write data
	output logic out_valid, // word available
	input wire logic out_ready, // consumer takes word
	output logic [WIDTH-1:0] out_data // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	wire ptr_lap = wr_q[AW] != rd_q[AW];
	wire ptr_same = wr_q[AW-1:0] == rd_q[AW-1:0];

	assign in_ready = !(ptr_lap && ptr_same);
	assign out_valid = !(!ptr_lap && ptr_same);
	assign out_data = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (!nrst || flush) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end
endmodule : rnr_fifo

// ---- rnr_pkg.sv ----
// Purpose: types of the serial ROM readout block
// Assumes: constants live in rnr_defines.svh
// Notes: none
package rnr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'H0,
		ST_SYNC = 3'H1,
		ST_FETCH = 3'H2,
		ST_PUSH = 3'H3,
		ST_WAIT = 3'H4
	} rnr_state_type;
	typedef logic [17:0] rnr_addr_type;
	typedef logic [7:0] rnr_word_type;
endpackage : rnr_pkg

// ---- rnr_rom.sv ----
// Purpose: 128K-bit byte-wide storage array with registered read
// Assumes: contents fixed at build time
// Notes: contents stand in as a fixed pattern of the address
`timescale 1ns/1ps
`include "rnr_defines.svh"
module rnr_rom (
	input wire logic clk_sys, // system clock
	input wire logic rd_en, // read strobe
	input wire logic [`RNR_ROM_AW-1:0] rd_addr, // byte address
	output rnr_pkg::rnr_word_type rd_data // registered byte
);
	import rnr_pkg::*;
	// mask pattern: no file load, so a fixed mix of address bits
	wire rnr_word_type pattern = rd_addr[7:0] ^ {rd_addr[13:8], 2'H0} ^ 8'H5A;

	always_ff @(posedge clk_sys) begin
		if (rd_en)
			rd_data <= pattern;
	end
endmodule : rnr_rom

// ---- rnr_tb.sv ----
// Purpose: self-checking bench of the serial ROM readout block
// Assumes: stimulus at clk_sys rising edge
// Notes: pulses last 11 cycles, far above sync latency
`timescale 1ns/1ps
module testbench;
	import rnr_pkg::*;
	logic clk_sys, nrst, power_down, address_strobe, data_request_pulse, mode_sel, nibble_select;
	logic [3:0] addr_nibble_in;
	logic base_clock_in, parallel_data_oe, serial_data_out, data_valid;
	logic [7:0] parallel_data_in, parallel_data_out;
	rnr_addr_type ext_addr_out;
	int error_cnt, checked;
	localparam rnr_addr_type A = 18'H02A5C;
	localparam rnr_addr_type B = 18'H1C0A9;
	rnr_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .base_clock_in(base_clock_in), .power_down(power_down),
		.address_strobe(address_strobe), .addr_nibble_in(addr_nibble_in), .data_request_pulse(data_request_pulse),
		.mode_sel(mode_sel), .nibble_select(nibble_select), .parallel_data_in(parallel_data_in),
		.parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
		.serial_data_out(serial_data_out), .ext_addr_out(ext_addr_out), .data_valid(data_valid));
	rnr_far_side far_u (.ext_addr_out(ext_addr_out), .parallel_data_out(parallel_data_out),
		.parallel_data_oe(parallel_data_oe), .base_clock_in(base_clock_in), .parallel_data_in(parallel_data_in));
	initial begin
		clk_sys = 1'H0;
		forever #5 clk_sys = ~clk_sys;
	end
	function automatic rnr_word_type rom_of(input rnr_addr_type a);
		return a[7:0] ^ {a[13:8], 2'H0} ^ 8'H5A;
	endfunction : rom_of
	task automatic close_out();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic req();
		@(posedge clk_sys);
		data_request_pulse <= 1'H1;
		tick(10);
		@(posedge clk_sys);
		data_request_pulse <= 1'H0;
		tick(10);
	endtask : req
	task automatic load(input rnr_addr_type a);
		logic [19:0] s;
		s = {2'H3, a};
		for (int i = 4; i >= 0; i--) begin
			@(posedge clk_sys);
			addr_nibble_in <= s[i*4 +: 4];
			address_strobe <= 1'H1;
			tick(10);
			@(posedge clk_sys);
			address_strobe <= 1'H0;
			tick(10);
		end
	endtask : load
	task automatic wait_valid();
		int n;
		n = 0;
		while (data_valid !== 1'H1 && n < 3000) begin
			tick(1);
			n++;
		end
		check(18'(data_valid), 18'H1, "no data presented");
	endtask : wait_valid
	task automatic s_serial();
		rnr_word_type w;
		w = rom_of(A);
		@(posedge clk_sys);
		mode_sel <= 1'H0;
		load(A);
		check(ext_addr_out, A, "address load");
		wait_valid();
		check(18'(parallel_data_oe), 18'H1, "port not driven");
		for (int i = 0; i < 8; i++) begin
			if (i > 0) req();
			check(18'(serial_data_out), 18'(w[i]), "serial bit");
		end
		tick(500);
		req();
		wait_valid();
		check(ext_addr_out, A + 18'H1, "serial next address");
		check(18'(serial_data_out), 18'(rom_of(A + 18'H1) & 8'H01), "next word bit 0");
		req();
		check(18'(serial_data_out), 18'(rom_of(A + 18'H1) >> 1 & 8'H01), "next word bit 1");
	endtask : s_serial
	task automatic s_parallel();
		rnr_word_type w;
		w = rom_of(A + 18'H2);
		tick(500);
		@(posedge clk_sys);
		mode_sel <= 1'H1;
		req();
		wait_valid();
		check(ext_addr_out, A + 18'H2, "parallel next address");
		tick(2);
		check(18'(parallel_data_out), 18'(w), "low nibble");
		@(posedge clk_sys);
		nibble_select <= 1'H1;
		tick(10);
		check(18'(parallel_data_out), 18'({w[7:4], w[7:4]}), "high nibble");
		@(posedge clk_sys);
		nibble_select <= 1'H0;
	endtask : s_parallel
	task automatic s_power_down();
		tick(500);
		@(posedge clk_sys);
		power_down <= 1'H1;
		tick(6);
		load(18'H01111);
		check(ext_addr_out, 18'H0, "address kept in power-down");
		check(18'(data_valid), 18'H0, "valid in power-down");
		@(posedge clk_sys);
		power_down <= 1'H0;
		tick(10);
		req();
		wait_valid();
		check(ext_addr_out, 18'H0, "address after release");
		tick(2);
		check(18'(parallel_data_out), 18'(rom_of(18'H0)), "word at zero");
	endtask : s_power_down
	task automatic s_external();
		rnr_word_type e;
		e = B[7:0] ^ 8'HC3;
		tick(500);
		@(posedge clk_sys);
		power_down <= 1'H1;
		mode_sel <= 1'H0;
		tick(6);
		@(posedge clk_sys);
		power_down <= 1'H0;
		tick(6);
		load(B);
		wait_valid();
		check(18'(parallel_data_oe), 18'H0, "port driven on miss");
		check(18'(serial_data_out), 18'(e[0]), "external bit 0");
		req();
		check(18'(serial_data_out), 18'(e[1]), "external bit 1");
	endtask : s_external
	initial begin
		nrst = 1'H0;
		power_down = 1'H0;
		address_strobe = 1'H0;
		addr_nibble_in = 4'H0;
		data_request_pulse = 1'H0;
		mode_sel = 1'H0;
		nibble_select = 1'H0;
		error_cnt = 0;
		checked = 0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'H1;
		tick(4);
		@(posedge clk_sys);
		power_down <= 1'H1;
		tick(8);
		@(posedge clk_sys);
		power_down <= 1'H0;
		tick(8);
		s_serial();
		s_parallel();
		s_power_down();
		s_external();
		close_out();
	end
	// full run is near 16k cycles
	initial begin
		#400000;
		error_cnt++;
		close_out();
	end
endmodule : testbench

// ---- rnr_top.sv ----
// Purpose: readout logic of a 128K-bit ROM, nibble address load, serial or parallel read
// Assumes: all pins asynchronous to clk_sys; base clock far slower than clk_sys
// Notes: power-down holds the last presented data; counters cleared
// Overview of operation
// - each strobe latches one slice, most significant first; the first slice is 2 bits, the rest 4
// - readout starts when the fifth strobe pulse falls
// - request fall starts readout; first in parallel mode, eighth in serial mode
// - after access time, bit 0 on serial output, byte on parallel port
// - access delay is 25.6 us from start to valid data
// - each serial request pulse advances serial output to next higher bit; the eighth wraps it back to bit 0
// - nibble select puts bits 0-3 or 4-7 on low parallel lines
// - stored byte loads in parallel into a shift register, shifted out
// - address bits 14 to 17 compared with fixed chip-select code
// - on match, ROM read enabled and parallel port drives out
// - on mismatch, ROM read inhibited and parallel port becomes input
// - in input mode the external byte is shifted out serially
// - 18-bit address counter value driven on address outputs
// - storage holds 128K bits as bytes on low address bits
// - after power-down falls, a readout may start at any time
// - after delivery, next qualifying request reads the following address
// - power-down ignores strobe and request inputs and clears the four counters
`timescale 1ns/1ps
`include "rnr_defines.svh"
module rnr_top (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // sync reset, active low
	input wire logic base_clock_in, // base clock from host
	input wire logic power_down, // power-down, active high
	input wire logic address_strobe, // address slice strobe
	input wire logic [3:0] addr_nibble_in, // address slice
	input wire logic data_request_pulse, // data request / shift clock
	input wire logic mode_sel, // low serial, high parallel
	input wire logic nibble_select, // low bits 0-3, high bits 4-7
	input wire logic [7:0] parallel_data_in, // parallel port input side
	output logic [7:0] parallel_data_out, // parallel port output side
	output logic parallel_data_oe, // parallel port drive enable
	output logic serial_data_out, // serial data
	output rnr_pkg::rnr_addr_type ext_addr_out, // external memory address
	output logic data_valid // presented data valid
);
	import rnr_pkg::*;

	// pin synchronisers, first stage read only by second
	logic [`RNR_PIN_W-1:0] pin_meta_q;
	logic [`RNR_PIN_W-1:0] pin_sync_q;
	wire [`RNR_PIN_W-1:0] pin_raw = {base_clock_in, power_down,
		address_strobe, data_request_pulse, mode_sel, nibble_select,
		addr_nibble_in, parallel_data_in};

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	wire base_s = pin_sync_q[17];
	wire pd_s = pin_sync_q[16];
	wire stb_s = pin_sync_q[15];
	wire req_s = pin_sync_q[14];
	wire mode_s = pin_sync_q[13];
	wire nsel_s = pin_sync_q[12];
	wire [3:0] nib_s = pin_sync_q[11:8];
	wire [7:0] ext_s = pin_sync_q[7:0];

	// edge detection on synchronised levels
	logic base_prev_q;
	logic stb_prev_q;
	logic req_prev_q;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			base_prev_q <= 1'b0;
			stb_prev_q <= 1'b0;
			req_prev_q <= 1'b0;
		end else begin
			base_prev_q <= base_s;
			stb_prev_q <= stb_s;
			req_prev_q <= req_s;
		end
	end

	// strobe and request falls ignored while powered down
	wire base_rise = base_s & ~base_prev_q;
	wire stb_fall = stb_prev_q & ~stb_s & ~pd_s;
	wire req_fall = req_prev_q & ~req_s & ~pd_s;

	// state
	rnr_state_type state_q;
	rnr_state_type state_d;
	rnr_addr_type addr_q;
	rnr_addr_type addr_d;
	logic [2:0] stb_cnt_q;
	logic [2:0] req_cnt_q;
	logic [`RNR_TIMER_W-1:0] timer_q;
	logic delivered_q;
	logic src_rom_q;
	rnr_word_type ext_q;
	rnr_word_type word_q;
	rnr_word_type shift_q;
	logic data_valid_q;
	logic par_oe_q;
	rnr_word_type par_out_q;

	// start and advance decoding
	wire last_slice = stb_cnt_q == `RNR_SLICE_LAST;
	wire start_stb = stb_fall & last_slice;
	wire serial_mode = ~mode_s;
	wire req_last = req_cnt_q == `RNR_BIT_LAST;
	wire req_qual = req_fall & (mode_s | req_last);
	wire idle = state_q == ST_IDLE;
	wire start_rd = idle & (start_stb | req_qual);
	wire next_addr = req_qual & delivered_q & ~start_stb;
	wire cs_hit = addr_q[`RNR_CS_MSB:`RNR_CS_LSB] == `RNR_CS_CODE;

	// fetch path through the FIFO
	logic fifo_in_ready;
	logic fifo_out_valid;
	rnr_word_type fifo_out_data;
	rnr_word_type rom_data;
	wire rom_rd = (state_q == ST_FETCH) & src_rom_q;
	wire push_valid = state_q == ST_PUSH;
	wire timer_done = timer_q == '0;
	// a base rise right after the address moves would catch a stale external byte
	wire settled = timer_q <= `RNR_TIMER_W'(`RNR_ACCESS_CYC - 1 - `RNR_SETTLE_CYC);
	wire pop = (state_q == ST_WAIT) & timer_done & fifo_out_valid;
	// mismatch steers the external byte into the same path
	wire rnr_word_type fetched = src_rom_q ? rom_data : ext_q;
	wire rnr_addr_type addr_inc = addr_q + 18'H00001;

	rnr_rom u_rom (
		.clk_sys(clk_sys),
		.rd_en(rom_rd),
		.rd_addr(addr_q[`RNR_ROM_AW-1:0]),
		.rd_data(rom_data)
	);

	rnr_fifo #(
		.WIDTH(`RNR_WORD_W),
		.DEPTH(`RNR_FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.flush(pd_s),
		.in_valid(push_valid),
		.in_ready(fifo_in_ready),
		.in_data(fetched),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	// address counter: slice loads, then increments between words
	always_comb begin
		addr_d = addr_q;
		if (stb_fall) begin
			unique case (stb_cnt_q)
				`RNR_SLICE_TOP: addr_d[17:16] = nib_s[1:0];
				`RNR_SLICE_B: addr_d[15:12] = nib_s;
				`RNR_SLICE_C: addr_d[11:8] = nib_s;
				`RNR_SLICE_D: addr_d[7:4] = nib_s;
				`RNR_SLICE_LAST: addr_d[3:0] = nib_s;
				default: addr_d = addr_q;
			endcase
		end else if (next_addr && idle) begin
			addr_d = addr_inc;
		end
	end

	// read sequencer, paced by the base clock
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start_rd)
					state_d = ST_SYNC;
			end
			ST_SYNC: begin
				if (base_rise && settled)
					state_d = ST_FETCH;
			end
			ST_FETCH: state_d = ST_PUSH;
			ST_PUSH: begin
				if (fifo_in_ready)
					state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (pop)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst || pd_s) begin
			state_q <= ST_IDLE;
			addr_q <= '0;
			stb_cnt_q <= '0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			if (stb_fall)
				stb_cnt_q <= last_slice ? 3'H0 : stb_cnt_q + 3'H1;
		end
	end

	// request counter: counts only in serial mode, wraps after eight
	always_ff @(posedge clk_sys) begin
		if (!nrst || pd_s) begin
			req_cnt_q <= '0;
		end else if (start_stb) begin
			req_cnt_q <= '0;
		end else if (req_fall && serial_mode) begin
			req_cnt_q <= req_cnt_q + 3'H1;
		end
	end

	// access timer, the read-pulse counter
	always_ff @(posedge clk_sys) begin
		if (!nrst || pd_s) begin
			timer_q <= '0;
		end else if (start_rd) begin
			timer_q <= `RNR_TIMER_W'(`RNR_ACCESS_CYC - 1);
		end else if (!timer_done) begin
			timer_q <= timer_q - `RNR_TIMER_W'(1);
		end
	end

	// source choice and external byte capture at fetch time
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			src_rom_q <= 1'b0;
			ext_q <= '0;
		end else if (state_q == ST_SYNC && base_rise && settled) begin
			src_rom_q <= cs_hit;
			ext_q <= ext_s;
		end
	end

	// delivered flag: set by presentation, cleared by the next read
	always_ff @(posedge clk_sys) begin
		if (!nrst || pd_s) begin
			delivered_q <= 1'b0;
		end else if (pop) begin
			delivered_q <= 1'b1;
		end else if (start_rd) begin
			delivered_q <= 1'b0;
		end
	end

	// presented word and serial shifter; held through power-down
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			word_q <= '0;
			shift_q <= '0;
		end else if (pop) begin
			word_q <= fifo_out_data;
			shift_q <= fifo_out_data;
		end else if (req_fall && serial_mode) begin
			// rotate so position wraps back to bit 0 after eight
			shift_q <= {shift_q[0], shift_q[7:1]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			data_valid_q <= 1'b0;
		end else if (pop) begin
			data_valid_q <= 1'b1;
		end else if (start_rd || pd_s) begin
			data_valid_q <= 1'b0;
		end
	end

	// parallel port drive and nibble steering
	wire [3:0] low_lines = nsel_s ? word_q[7:4] : word_q[3:0];

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			par_oe_q <= 1'b0;
			par_out_q <= '0;
		end else begin
			par_oe_q <= cs_hit;
			par_out_q <= {word_q[7:4], low_lines};
		end
	end

	assign parallel_data_out = par_out_q;
	assign parallel_data_oe = par_oe_q;
	assign serial_data_out = shift_q[0];
	assign ext_addr_out = addr_q;
	assign data_valid = data_valid_q;
endmodule : rnr_top
